// file: as_params.svh
// Register map, field positions, reset values and timing counts of the serial core
`ifndef AS_PARAMS_SVH
`define AS_PARAMS_SVH
`define AS_OFF_CTRL  8'h00
`define AS_OFF_BAUD  8'h04
`define AS_OFF_STAT  8'h08
`define AS_OFF_FCLR  8'h0c
`define AS_OFF_TXD   8'h10
`define AS_OFF_RXD   8'h14
`define AS_OFF_REQ   8'h18
`define AS_C_UE      0
`define AS_C_TE      1
`define AS_C_RE      2
`define AS_C_WL      3
`define AS_C_PEN     4
`define AS_C_PODD    5
`define AS_C_OS8     6
`define AS_C_STOP2   7
`define AS_C_DMA     8
`define AS_C_TXEIE   9
`define AS_C_TCIE    10
`define AS_C_RXIE    11
`define AS_C_IDIE    12
`define AS_C_ERIE    13
`define AS_CTRL_W    14
`define AS_S_TBE     0
`define AS_S_TC      1
`define AS_S_RXNE    2
`define AS_S_IDLE    3
`define AS_S_ORE     4
`define AS_S_NF      5
`define AS_S_FE      6
`define AS_S_PE      7
`define AS_CTRL_RST  14'h0000
`define AS_BAUD_RST  16'h0010
`define AS_ACC_STEP  17'h00010
`define AS_OS_16     5'h10
`define AS_OS_8      5'h08
`define AS_PAY_9     4'h9
`define AS_PAY_8     4'h8
`define AS_FRM_ONES  12'hfff
`endif

// file: as_pkg.sv
// Types shared by the serial core
package as_pkg;
  typedef logic [7:0] as_addr_t;
  typedef enum logic [0:0] {TX_WAIT, TX_SHIFT} as_tx_st_t;
  typedef enum logic [0:0] {RX_IDLE, RX_FRAME} as_rx_st_t;
endpackage : as_pkg

// file: as_core.sv
// Asynchronous serial transmitter and receiver with APB registers
// Overview of operation
// R1: Data write clears empty flag; interrupt if enabled.
// R2: Busy transmitter holds new byte in buffer.
// R3: Idle transmitter loads shifter, empty flag returns.
// R4: Frame end with empty buffer sets complete.
// R5: Transmit least significant bit first.
// R6: Break request sends zero frame, then self-clears.
// R7: Break frame followed by configured stop bits.
// R8: Request cleared before start sends no break.
// R9: Transmit enable sends one idle frame first.
// R10: Receive LSB first; full flag with interrupt.
// R11: Single buffer: read or write-zero clears full.
// R12: Multi buffer: DMA data read clears full.
// R13: Received all-zero break reports framing error.
// R14: Idle line detection raises enabled interrupt.
// R15: Select eight or sixteen samples per bit.
// R16: Overrun keeps old data, drops new one.
// R17: Overrun interrupts on receive or error enable.
// R18: Status read then data read clears overrun.
// R19: Noise flag set with full flag; data kept.
// R20: Bad stop sets framing error; multi-buffer interrupt.
// R21: Software avoids eight samples in special modes.
// R22: Divider twelve integer, four fraction bits.
// R23: Length and parity bits define data width.
// R24: Even or odd parity replaces top bit.
// R25: Three centre samples, majority, noise on disagreement.
// R26: Software waits for completion before disabling.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "as_params.svh"
module as_core (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire as_pkg::as_addr_t paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             rx_pin,
  output logic                  tx_pin,
  output logic                  irq
);
  import as_pkg::*;

  function automatic logic hit(input as_addr_t a, input as_addr_t o);
    return a == o;
  endfunction : hit

  function automatic logic [8:0] pay_f(input logic [8:0] d, input logic wl,
                                       input logic pe, input logic odd);
    logic [8:0] p;
    p = wl ? d : {1'b1, d[7:0]};
    if (pe && wl)
      p[8] = (^d[7:0]) ^ odd;
    else if (pe)
      p[7] = (^d[6:0]) ^ odd;
    return p;
  endfunction : pay_f

  logic [`AS_CTRL_W-1:0] ctrl_reg;
  logic [15:0]           baud_divider_reg;
  logic [8:0]            tx_data_reg;
  logic [8:0]            rx_data_reg;
  logic [31:0]           prdata_reg;
  logic                  pready_reg;
  logic                  pslverr_reg;
  logic                  irq_reg;
  logic                  tx_buffer_empty_flag;
  logic                  tx_complete_flag;
  logic                  rx_not_empty_flag;
  logic                  idle_flag;
  logic                  overrun_flag;
  logic                  noise_flag;
  logic                  framing_error_flag;
  logic                  parity_error_flag;
  logic                  break_send_request;
  logic                  ore_armed_reg;
  logic                  idle_pend_reg;
  logic                  te_d_reg;
  logic [16:0]           acc_reg;
  logic                  tick_reg;
  as_tx_st_t             tx_st_reg;
  logic [11:0]           tx_sh_reg;
  logic [3:0]            tx_bit_reg;
  logic [4:0]            tx_os_reg;
  logic                  brk_act_reg;
  logic                  rx_s1_reg;
  logic                  rx_s2_reg;
  logic                  rx_s3_reg;
  as_rx_st_t             rx_st_reg;
  logic [4:0]            rx_os_reg;
  logic [3:0]            rx_bit_reg;
  logic [2:0]            smp_reg;
  logic [10:0]           rx_sh_reg;
  logic                  rx_nf_reg;
  logic [7:0]            idle_cnt_reg;
  logic                  idle_arm_reg;
  logic [31:0]           rd_mux;

  wire block_enable       = ctrl_reg[`AS_C_UE];
  wire transmitter_enable = ctrl_reg[`AS_C_TE];
  wire receiver_enable    = ctrl_reg[`AS_C_RE];
  wire word_length_sel    = ctrl_reg[`AS_C_WL];
  wire parity_enable      = ctrl_reg[`AS_C_PEN];
  wire parity_odd_sel     = ctrl_reg[`AS_C_PODD];
  wire oversample_sel     = ctrl_reg[`AS_C_OS8];
  wire stop_bits_sel      = ctrl_reg[`AS_C_STOP2];
  wire dma_multi_buf      = ctrl_reg[`AS_C_DMA];
  wire tx_empty_irq_en    = ctrl_reg[`AS_C_TXEIE];
  wire tx_done_irq_en     = ctrl_reg[`AS_C_TCIE];
  wire rx_full_irq_en     = ctrl_reg[`AS_C_RXIE];
  wire line_idle_irq_en   = ctrl_reg[`AS_C_IDIE];
  wire error_irq_en       = ctrl_reg[`AS_C_ERIE];

  // Bus decode
  wire setup   = psel && !penable && !pready_reg;
  wire acc_ph  = psel && penable && pready_reg;
  wire wr      = acc_ph && pwrite;
  wire rd      = acc_ph && !pwrite;
  wire wr_ctrl = wr && hit(paddr, `AS_OFF_CTRL);
  wire wr_baud = wr && hit(paddr, `AS_OFF_BAUD);
  wire wr_stat = wr && hit(paddr, `AS_OFF_STAT);
  wire wr_fclr = wr && hit(paddr, `AS_OFF_FCLR);
  wire wr_txd  = wr && hit(paddr, `AS_OFF_TXD);
  wire wr_req  = wr && hit(paddr, `AS_OFF_REQ);
  wire rd_stat = rd && hit(paddr, `AS_OFF_STAT);
  wire rd_rxd  = rd && hit(paddr, `AS_OFF_RXD);
  wire mapped  = hit(paddr, `AS_OFF_CTRL) || hit(paddr, `AS_OFF_BAUD) ||
                 hit(paddr, `AS_OFF_STAT) || hit(paddr, `AS_OFF_FCLR) ||
                 hit(paddr, `AS_OFF_TXD) || hit(paddr, `AS_OFF_RXD) ||
                 hit(paddr, `AS_OFF_REQ);

  // Frame geometry
  wire [4:0] osr   = oversample_sel ? `AS_OS_8 : `AS_OS_16; // [R15]
  wire [4:0] half  = {1'b0, osr[4:1]};
  wire [3:0] pay_n = word_length_sel ? `AS_PAY_9 : `AS_PAY_8; // [R23]
  wire [3:0] frm_n = pay_n + (stop_bits_sel ? 4'h3 : 4'h2);
  wire [7:0] idle_ticks = {4'h0, frm_n} * {3'h0, osr};

  always_comb
  begin
    case (paddr)
      `AS_OFF_CTRL: rd_mux = {18'h0, ctrl_reg};
      `AS_OFF_BAUD: rd_mux = {16'h0, baud_divider_reg};
      `AS_OFF_STAT: rd_mux = {24'h0, parity_error_flag, framing_error_flag, noise_flag,
                              overrun_flag, idle_flag, rx_not_empty_flag,
                              tx_complete_flag, tx_buffer_empty_flag};
      `AS_OFF_TXD:  rd_mux = {23'h0, tx_data_reg};
      `AS_OFF_RXD:  rd_mux = {23'h0, rx_data_reg};
      `AS_OFF_REQ:  rd_mux = {31'h0, break_send_request};
      default:      rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= setup;
      if (setup)
      begin
        prdata_reg  <= pwrite ? 32'h0 : rd_mux;
        pslverr_reg <= !mapped;
      end
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_reg         <= `AS_CTRL_RST;
      baud_divider_reg <= `AS_BAUD_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= pwdata[`AS_CTRL_W-1:0];
      if (wr_baud)
        baud_divider_reg <= pwdata[15:0]; // [R22]
    end

  // Fractional divider: one oversampling tick per divisor/16 clocks
  wire [16:0] acc_sum = acc_reg + `AS_ACC_STEP;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      acc_reg  <= 17'h0;
      tick_reg <= 1'b0;
    end
    else if (!block_enable)
    begin
      acc_reg  <= 17'h0;
      tick_reg <= 1'b0;
    end
    else if (acc_sum >= {1'b0, baud_divider_reg})
    begin
      acc_reg  <= acc_sum - {1'b0, baud_divider_reg}; // [R22]
      tick_reg <= 1'b1;
    end
    else
    begin
      acc_reg  <= acc_sum;
      tick_reg <= 1'b0;
    end

  // Transmitter
  wire tx_go   = block_enable && transmitter_enable && !wr_txd;
  wire tx_load = tx_st_reg == TX_WAIT && tx_go &&
                 (idle_pend_reg || break_send_request || !tx_buffer_empty_flag);
  wire tx_dload = tx_load && !idle_pend_reg && !break_send_request;
  wire tx_bend = tx_st_reg == TX_SHIFT && tick_reg && tx_os_reg == osr - 5'h1;
  wire tx_done = tx_bend && tx_bit_reg == 4'h1;
  wire [11:0] brk_frm = word_length_sel ? {2'b11, 10'h0} : {3'b111, 9'h0};

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tx_st_reg   <= TX_WAIT;
      tx_sh_reg   <= `AS_FRM_ONES;
      tx_bit_reg  <= 4'h0;
      tx_os_reg   <= 5'h0;
      brk_act_reg <= 1'b0;
    end
    else
      case (tx_st_reg)
        TX_WAIT:
          if (tx_load)
          begin
            tx_st_reg   <= TX_SHIFT;
            tx_os_reg   <= 5'h0;
            tx_bit_reg  <= frm_n;
            brk_act_reg <= !idle_pend_reg && break_send_request;
            if (idle_pend_reg)
              tx_sh_reg <= `AS_FRM_ONES; // [R9]
            else if (break_send_request)
              tx_sh_reg <= brk_frm; // [R6] [R7] [R8]
            else
              tx_sh_reg <= {2'b11, pay_f(tx_data_reg, word_length_sel, parity_enable,
                                         parity_odd_sel), 1'b0}; // [R24]
          end
        TX_SHIFT:
          if (tick_reg)
          begin
            tx_os_reg <= tx_bend ? 5'h0 : tx_os_reg + 5'h1;
            if (tx_bend)
            begin
              tx_sh_reg  <= {1'b1, tx_sh_reg[11:1]}; // [R5]
              tx_bit_reg <= tx_bit_reg - 4'h1;
            end
            if (tx_done)
              tx_st_reg <= TX_WAIT;
          end
        default: tx_st_reg <= TX_WAIT;
      endcase

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tx_data_reg          <= 9'h0;
      tx_buffer_empty_flag <= 1'b1;
      tx_complete_flag     <= 1'b0;
      break_send_request   <= 1'b0;
      idle_pend_reg        <= 1'b0;
      te_d_reg             <= 1'b0;
    end
    else
    begin
      te_d_reg <= transmitter_enable;
      if (wr_txd)
        tx_data_reg <= pwdata[8:0];
      if (tx_dload)
        tx_buffer_empty_flag <= 1'b1; // [R2] [R3]
      else if (wr_txd)
        tx_buffer_empty_flag <= 1'b0; // [R1]
      if (tx_done && tx_buffer_empty_flag && !break_send_request)
        tx_complete_flag <= 1'b1; // [R4]
      else if (wr_txd || (wr_fclr && pwdata[`AS_S_TC]))
        tx_complete_flag <= 1'b0;
      if (wr_req && pwdata[0])
        break_send_request <= 1'b1;
      else if ((tx_done && brk_act_reg) || wr_req)
        break_send_request <= 1'b0; // [R6] [R8]
      if (transmitter_enable && !te_d_reg)
        idle_pend_reg <= 1'b1; // [R9]
      else if ((tx_load && idle_pend_reg) || !transmitter_enable)
        idle_pend_reg <= 1'b0;
    end

  // Receiver
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_s3_reg <= 1'b1;
    end
    else
    begin
      rx_s1_reg <= rx_pin;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
    end

  wire maj    = (smp_reg[0] & smp_reg[1]) | (smp_reg[0] & smp_reg[2]) |
                (smp_reg[1] & smp_reg[2]); // [R25]
  wire noisy  = (|smp_reg) && !(&smp_reg);
  wire rx_bend = rx_st_reg == RX_FRAME && tick_reg && rx_os_reg == osr - 5'h1;
  wire rx_fin = rx_bend && rx_bit_reg == pay_n + 4'h1;
  wire [8:0] rx_dat = word_length_sel ? rx_sh_reg[9:1] : {1'b0, rx_sh_reg[8:1]};
  wire rx_perr = parity_enable && ((^rx_dat) ^ parity_odd_sel); // [R24]
  wire rx_store = rx_fin && !rx_not_empty_flag;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rx_st_reg  <= RX_IDLE;
      rx_os_reg  <= 5'h0;
      rx_bit_reg <= 4'h0;
      smp_reg    <= 3'h7;
      rx_sh_reg  <= 11'h0;
      rx_nf_reg  <= 1'b0;
    end
    else
      case (rx_st_reg)
        RX_IDLE:
          if (block_enable && receiver_enable && rx_s3_reg && !rx_s2_reg)
          begin
            rx_st_reg  <= RX_FRAME;
            rx_os_reg  <= 5'h0;
            rx_bit_reg <= 4'h0;
            rx_nf_reg  <= 1'b0;
          end
        RX_FRAME:
          if (tick_reg)
          begin
            rx_os_reg <= rx_bend ? 5'h0 : rx_os_reg + 5'h1;
            if (rx_os_reg == half - 5'h1)
              smp_reg[0] <= rx_s2_reg; // [R25]
            if (rx_os_reg == half)
              smp_reg[1] <= rx_s2_reg;
            if (rx_os_reg == half + 5'h1)
              smp_reg[2] <= rx_s2_reg;
            if (rx_bend)
            begin
              rx_sh_reg[rx_bit_reg] <= maj; // [R10]
              rx_bit_reg <= rx_bit_reg + 4'h1;
              rx_nf_reg  <= rx_nf_reg | noisy;
              if ((rx_bit_reg == 4'h0 && maj) || rx_fin)
                rx_st_reg <= RX_IDLE;
            end
          end
        default: rx_st_reg <= RX_IDLE;
      endcase

  // Idle line: one frame time of high after a character
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      idle_cnt_reg <= 8'h0;
      idle_arm_reg <= 1'b0;
    end
    else
    begin
      if (rx_st_reg != RX_IDLE || !rx_s2_reg || !idle_arm_reg)
        idle_cnt_reg <= 8'h0;
      else if (tick_reg)
        idle_cnt_reg <= idle_cnt_reg + 8'h1;
      if (rx_fin)
        idle_arm_reg <= 1'b1;
      else if (idle_cnt_reg == idle_ticks)
        idle_arm_reg <= 1'b0;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rx_data_reg        <= 9'h0;
      rx_not_empty_flag  <= 1'b0;
      overrun_flag       <= 1'b0;
      ore_armed_reg      <= 1'b0;
      noise_flag         <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag  <= 1'b0;
      idle_flag          <= 1'b0;
    end
    else
    begin
      if (rx_store)
        rx_data_reg <= rx_dat; // [R16] [R19] [R20]
      if (rx_store)
        rx_not_empty_flag <= 1'b1; // [R10] [R12]
      else if (rd_rxd || (wr_stat && !pwdata[`AS_S_RXNE] && !dma_multi_buf))
        rx_not_empty_flag <= 1'b0; // [R11] [R12]
      if (rx_fin && rx_not_empty_flag)
        overrun_flag <= 1'b1; // [R16]
      else if (ore_armed_reg && rd_rxd)
        overrun_flag <= 1'b0; // [R18]
      if (rd_stat)
        ore_armed_reg <= 1'b1;
      else if (rd_rxd)
        ore_armed_reg <= 1'b0;
      if (rx_store && (rx_nf_reg || noisy))
        noise_flag <= 1'b1; // [R19]
      else if (wr_fclr && pwdata[`AS_S_NF])
        noise_flag <= 1'b0;
      if (rx_store && !maj)
        framing_error_flag <= 1'b1; // [R13] [R20]
      else if (wr_fclr && pwdata[`AS_S_FE])
        framing_error_flag <= 1'b0;
      if (rx_store && rx_perr)
        parity_error_flag <= 1'b1; // [R24]
      else if (wr_fclr && pwdata[`AS_S_PE])
        parity_error_flag <= 1'b0;
      if (idle_arm_reg && idle_cnt_reg == idle_ticks)
        idle_flag <= 1'b1; // [R14]
      else if (wr_fclr && pwdata[`AS_S_IDLE])
        idle_flag <= 1'b0;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= (tx_buffer_empty_flag && tx_empty_irq_en) || // [R1]
                 (tx_complete_flag && tx_done_irq_en) || // [R4]
                 (rx_not_empty_flag && rx_full_irq_en) || // [R10]
                 (overrun_flag && (rx_full_irq_en || error_irq_en)) || // [R17]
                 (idle_flag && line_idle_irq_en) || // [R14]
                 (dma_multi_buf && error_irq_en &&
                  (noise_flag || framing_error_flag || parity_error_flag)); // [R20]

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_pin  = tx_sh_reg[0];
  assign irq     = irq_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_brk_end;
    tx_done && brk_act_reg && !wr_req;
  endsequence
  sequence s_line_high;
    tx_pin && tx_st_reg == TX_WAIT;
  endsequence

  chk_txe_clear: assert property (wr_txd |=> !tx_buffer_empty_flag) // [R1]
    else $error("empty flag not cleared by data write");
  chk_hold_busy: assert property (wr_txd && tx_st_reg == TX_SHIFT && !tx_done
                                  |=> !tx_buffer_empty_flag ##0 tx_st_reg == TX_SHIFT) // [R2]
    else $error("busy write not held in buffer");
  chk_direct_load: assert property (tx_dload |=> tx_buffer_empty_flag &&
                                    tx_st_reg == TX_SHIFT && !tx_pin) // [R3]
    else $error("idle write not loaded");
  chk_tc_set: assert property (tx_done && tx_buffer_empty_flag && !break_send_request
                               |=> tx_complete_flag) // [R4]
    else $error("complete flag missing");
  chk_brk_stop: assert property (s_brk_end |=> !break_send_request ##0 s_line_high) // [R6]
    else $error("break end wrong");
  chk_idle_first: assert property (tx_load && idle_pend_reg
                                   |=> tx_sh_reg == `AS_FRM_ONES ##1 tx_pin [*2]) // [R9]
    else $error("idle frame not sent first");
  chk_rxne_set: assert property (rx_store |=> rx_not_empty_flag &&
                                 rx_data_reg == $past(rx_dat)) // [R10]
    else $error("received word not stored");
  chk_rxne_read: assert property (rd_rxd && !rx_fin |=> !rx_not_empty_flag) // [R11]
    else $error("data read left full flag");
  chk_overrun_keep: assert property (rx_fin && rx_not_empty_flag
                                     |=> overrun_flag && $stable(rx_data_reg)) // [R16]
    else $error("overrun handled wrong");
  chk_ore_clear: assert property (ore_armed_reg && rd_rxd && !rx_fin |=> !overrun_flag) // [R18]
    else $error("overrun not cleared");
  chk_apb_ready: assert property (setup |=> pready_reg ##1 !pready_reg)
    else $error("bus answer timing wrong");
endmodule : as_core

// file: as_remote.sv
// Remote serial device model facing the core's TX and RX pins
`timescale 1ns/1ps
module as_remote (
  input  wire logic pclk,
  output logic      rx_pin,
  input  wire logic tx_pin
);
  initial rx_pin = 1'b1;

  // Frame onto RX, LSB first; g puts a one-cycle glitch in bit 2
  task automatic send(input logic [8:0] d, input int n, input int c, input logic sp,
                      input int g);
    int i;
    int k;
    for (i = 0; i < n + 2; i++)
    begin
      for (k = 0; k < c; k++)
      begin
        @(posedge pclk);
        rx_pin <= (i == 0) ? 1'b0 : (i > n) ? sp : d[i-1] ^ (i == 3 && k == g);
      end
    end
    @(posedge pclk);
    rx_pin <= 1'b1;
  endtask : send

  // Wait for a start bit, then sample each bit at its centre
  task automatic recv(input int n, input int c, output logic [8:0] d, output logic sp,
                      output int w);
    int i;
    d = '0;
    w = 0;
    while (tx_pin !== 1'b0 && w < 4000)
    begin
      @(posedge pclk);
      w++;
    end
    repeat (c / 2) @(posedge pclk);
    for (i = 0; i < n; i++)
    begin
      repeat (c) @(posedge pclk);
      d[i] = tx_pin;
    end
    repeat (c) @(posedge pclk);
    sp = tx_pin;
  endtask : recv
endmodule : as_remote

// file: as_core_tb_top.sv
// Self-checking bench for the serial core
`timescale 1ns/1ps
`include "as_params.svh"
module as_core_tb_top;
  import as_pkg::*;
  localparam logic [31:0] UE   = 32'h1 << `AS_C_UE;
  localparam logic [31:0] TE   = 32'h1 << `AS_C_TE;
  localparam logic [31:0] RE   = 32'h1 << `AS_C_RE;
  localparam logic [31:0] WL   = 32'h1 << `AS_C_WL;
  localparam logic [31:0] PEN  = 32'h1 << `AS_C_PEN;
  localparam logic [31:0] PODD = 32'h1 << `AS_C_PODD;
  localparam logic [31:0] OS8  = 32'h1 << `AS_C_OS8;
  localparam logic [31:0] DMA  = 32'h1 << `AS_C_DMA;
  localparam logic [31:0] TCIE = 32'h1 << `AS_C_TCIE;
  localparam logic [31:0] RXIE = 32'h1 << `AS_C_RXIE;
  localparam logic [31:0] IDIE = 32'h1 << `AS_C_IDIE;
  localparam logic [31:0] ERIE = 32'h1 << `AS_C_ERIE;
  localparam logic [31:0] TXEIE = 32'h1 << `AS_C_TXEIE;
  localparam logic [31:0] STOP2 = 32'h1 << `AS_C_STOP2;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  as_addr_t    paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_pin;
  logic        tx_pin;
  logic        irq;
  logic [31:0] rdat;
  logic        rerr;
  logic [8:0]  rd9;
  logic [8:0]  rd9b;
  logic        stp;
  int          w;
  int          err_total;
  int          checked;
  logic [31:0] fc [7] = '{PEN, PEN | PODD, WL, WL | PEN, OS8, 32'h0, STOP2 | PEN};
  logic [31:0] fb [7] = '{32'h10, 32'h10, 32'h10, 32'h10, 32'h10, 32'h28, 32'h10};
  logic [8:0]  fd [7] = '{9'h007, 9'h007, 9'h1a5, 9'h0a4, 9'h03c, 9'h0c5, 9'h070};
  logic [8:0]  fe [7] = '{9'h087, 9'h007, 9'h1a5, 9'h1a4, 9'h03c, 9'h0c5, 9'h0f0};
  int          fn [7] = '{8, 8, 9, 9, 8, 8, 8};
  int          fy [7] = '{16, 16, 16, 16, 8, 40, 16};

  as_core DUT (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rx_pin(rx_pin),
    .tx_pin(tx_pin),
    .irq(irq)
  );
  as_remote u_rem (.pclk(pclk), .rx_pin(rx_pin), .tx_pin(tx_pin));

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %0t: seen %h, expected %h", $time, s, e);
    end
  endtask : chk

  task automatic apb(input logic wr, input as_addr_t a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50)
      err_total++;
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rxf(input logic [8:0] d, input logic sp, input int g);
    u_rem.send(d, 8, 16, sp, g);
    repeat (4) @(posedge pclk);
  endtask : rxf

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #(40000 * 40);
    err_total++;
    report_and_stop();
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    err_total = 0;
    checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, unmapped access
    apb(1'b0, `AS_OFF_CTRL, '0);
    chk(rdat, 32'h0);
    apb(1'b0, `AS_OFF_BAUD, '0);
    chk(rdat, 32'h10);
    apb(1'b0, `AS_OFF_STAT, '0);
    chk(rdat, 32'h1 << `AS_S_TBE);
    apb(1'b0, 8'h1c, '0);
    chk({rdat[30:0], rerr}, 32'h1);
    // Empty-flag interrupt
    apb(1'b1, `AS_OFF_CTRL, TXEIE);
    apb(1'b0, `AS_OFF_CTRL, '0);
    chk(rdat, TXEIE);
    chk(32'(irq), 32'h1);
    // Idle frame, then first character
    fork
      u_rem.recv(8, 16, rd9, stp, w);
      begin
        apb(1'b1, `AS_OFF_CTRL, UE | TE | TCIE);
        apb(1'b1, `AS_OFF_TXD, 32'h0a5);
      end
    join
    chk(32'(rd9), 32'h0a5);
    chk(32'(w >= 160), 32'h1);
    repeat (20) @(posedge pclk);
    apb(1'b0, `AS_OFF_STAT, '0);
    chk(rdat & 32'h3, 32'h3);
    chk(32'(irq), 32'h1);
    // Second write while busy is held
    fork
      begin
        u_rem.recv(8, 16, rd9, stp, w);
        u_rem.recv(8, 16, rd9b, stp, w);
      end
      begin
        apb(1'b1, `AS_OFF_TXD, 32'h03c);
        apb(1'b1, `AS_OFF_TXD, 32'h0c3);
        apb(1'b0, `AS_OFF_STAT, '0);
        chk(rdat & 32'h3, 32'h0);
      end
    join
    chk({23'h0, rd9}, 32'h03c);
    chk({23'h0, rd9b}, 32'h0c3);
    repeat (20) @(posedge pclk);
    // Break withdrawn before it starts
    fork
      begin
        u_rem.recv(8, 16, rd9, stp, w);
        u_rem.recv(8, 16, rd9b, stp, w);
      end
      begin
        apb(1'b1, `AS_OFF_TXD, 32'h055);
        apb(1'b0, `AS_OFF_STAT, '0);
        chk(rdat & 32'h3, 32'h1);
        apb(1'b1, `AS_OFF_REQ, 32'h1);
        apb(1'b1, `AS_OFF_REQ, 32'h0);
      end
    join
    chk({23'h0, rd9}, 32'h055);
    chk(32'(w), 32'd4000);
    // Break frame
    fork
      u_rem.recv(8, 16, rd9, stp, w);
      apb(1'b1, `AS_OFF_REQ, 32'h1);
    join
    chk({22'h0, rd9, stp}, 32'h1);
    repeat (20) @(posedge pclk);
    apb(1'b0, `AS_OFF_REQ, '0);
    chk(rdat, 32'h0);
    // Frame formats, oversampling, fractional divider
    for (int j = 0; j < 7; j++)
    begin
      apb(1'b1, `AS_OFF_CTRL, UE);
      apb(1'b1, `AS_OFF_BAUD, fb[j]);
      fork
        u_rem.recv(fn[j], fy[j], rd9, stp, w);
        begin
          apb(1'b1, `AS_OFF_CTRL, UE | TE | fc[j]);
          apb(1'b1, `AS_OFF_TXD, {23'h0, fd[j]});
        end
      join
      chk({23'h0, rd9}, {23'h0, fe[j]});
      repeat (3 * fy[j]) @(posedge pclk); // Frame ends first
    end
    // Reception, idle line
    apb(1'b1, `AS_OFF_BAUD, 32'h10);
    apb(1'b1, `AS_OFF_CTRL, UE | RE | RXIE | IDIE);
    rxf(9'h03c, 1'b1, -1);
    apb(1'b0, `AS_OFF_STAT, '0);
    chk({30'h0, rdat[`AS_S_RXNE], irq}, 32'h3);
    apb(1'b0, `AS_OFF_RXD, '0);
    chk(rdat, 32'h03c);
    repeat (200) @(posedge pclk);
    apb(1'b0, `AS_OFF_STAT, '0);
    chk({29'h0, rdat[`AS_S_IDLE], rdat[`AS_S_RXNE], irq}, 32'h5);
    // Overrun on error enable only
    apb(1'b1, `AS_OFF_FCLR, 32'hff);
    apb(1'b1, `AS_OFF_CTRL, UE | RE | ERIE);
    rxf(9'h011, 1'b1, -1);
    rxf(9'h022, 1'b1, -1);
    apb(1'b0, `AS_OFF_STAT, '0);
    chk({30'h0, rdat[`AS_S_ORE], irq}, 32'h3);
    apb(1'b0, `AS_OFF_RXD, '0);
    chk(rdat, 32'h011);
    apb(1'b0, `AS_OFF_STAT, '0);
    chk({30'h0, rdat[`AS_S_ORE], irq}, 32'h0);
    // Clear by writing zero
    rxf(9'h05a, 1'b1, -1);
    apb(1'b1, `AS_OFF_STAT, '0);
    apb(1'b0, `AS_OFF_STAT, '0);
    chk(32'(rdat[`AS_S_RXNE]), 32'h0);
    // Noisy sample, single buffer
    rxf(9'h000, 1'b1, 10);
    apb(1'b0, `AS_OFF_STAT, '0);
    chk({29'h0, rdat[`AS_S_NF], rdat[`AS_S_RXNE], irq}, 32'h6);
    apb(1'b0, `AS_OFF_RXD, '0);
    chk(rdat, 32'h0);
    // Break received, multi-buffer
    apb(1'b1, `AS_OFF_FCLR, 32'hff);
    apb(1'b1, `AS_OFF_CTRL, UE | RE | ERIE | DMA);
    rxf(9'h000, 1'b0, -1);
    apb(1'b1, `AS_OFF_STAT, '0);
    apb(1'b0, `AS_OFF_STAT, '0);
    chk({29'h0, rdat[`AS_S_FE], rdat[`AS_S_RXNE], irq}, 32'h7);
    apb(1'b0, `AS_OFF_RXD, '0);
    apb(1'b0, `AS_OFF_STAT, '0);
    chk(32'(rdat[`AS_S_RXNE]), 32'h0);
    // Parity error on receive
    apb(1'b1, `AS_OFF_FCLR, 32'hff);
    apb(1'b1, `AS_OFF_CTRL, UE | RE | PEN);
    rxf(9'h001, 1'b1, -1);
    apb(1'b0, `AS_OFF_STAT, '0);
    chk({30'h0, rdat[`AS_S_PE], rdat[`AS_S_RXNE]}, 32'h3);
    report_and_stop();
  end
endmodule : as_core_tb_top
